// ==== common/ser_pkg.sv ====
// Constants and types for the status event reporting block
package ser_pkg;

   localparam int SER_DW = 16;
   localparam int SER_MW = 15;
   localparam logic [SER_MW-1:0] SER_MASK_RST = 15'h0000;

   // Power questionable bit positions
   localparam int PQ_OVL_A = 1;
   localparam int PQ_OVL_B = 2;
   localparam int PQ_ZER_A = 3;
   localparam int PQ_ZER_B = 4;
   localparam int PQ_MEAS_LO = 5;
   localparam int PQ_MEAS_N = 4;

   // Calibration condition bit positions
   localparam int CAL_CH_A = 1;
   localparam int CAL_CH_B = 2;

   // Operation condition bit positions
   localparam int OPR_CAL = 0;
   localparam int OPR_TRIG = 5;
   localparam int OPR_SENSE = 10;
   localparam int OPR_LLF = 11;
   localparam int OPR_ULF = 12;

   // Register selector codes
   typedef enum logic [3:0] {
      SEL_PWR_COND = 4'h0,
      SEL_DEV_COND = 4'h1,
      SEL_DEV_EVT = 4'h2,
      SEL_DEV_EN = 4'h3,
      SEL_DEV_PTR = 4'h4,
      SEL_DEV_NTR = 4'h5,
      SEL_CAL_COND = 4'h6,
      SEL_CAL_EVT = 4'h7,
      SEL_CAL_EN = 4'h8,
      SEL_CAL_PTR = 4'h9,
      SEL_CAL_NTR = 4'ha,
      SEL_OPR_COND = 4'hb,
      SEL_OPR_EVT = 4'hc,
      SEL_OPR_EN = 4'hd,
      SEL_OPR_PTR = 4'he,
      SEL_OPR_NTR = 4'hf
   } ser_sel_t;

   typedef struct packed {
      logic req;
      logic wr;
      ser_sel_t sel;
      logic [SER_DW-1:0] wdata;
   } ser_cmd_t;

   typedef struct packed {
      logic valid;
      logic [SER_DW-1:0] data;
   } ser_rsp_t;

endpackage : ser_pkg

// ==== rtl/ser_status_top.sv ====
// Status event reporting: power questionable, device, calibration and operation groups
`timescale 1ns/1ps

// Per-group condition edge filter, event latch and enable mask
module ser_group
   import ser_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [SER_MW-1:0] cond,
   input wire logic [SER_MW-1:0] wdata,
   input wire logic wr_en,
   input wire logic wr_ptr,
   input wire logic wr_ntr,
   input wire logic rd_evt,
   output logic [SER_MW-1:0] en_q,
   output logic [SER_MW-1:0] ptr_q,
   output logic [SER_MW-1:0] ntr_q,
   output logic [SER_MW-1:0] evt_q,
   output logic summary
);
   logic [SER_MW-1:0] en_ff;
   logic [SER_MW-1:0] ptr_ff;
   logic [SER_MW-1:0] ntr_ff;
   logic [SER_MW-1:0] evt_ff;
   logic [SER_MW-1:0] cond_ff;
   logic [SER_MW-1:0] rise;
   logic [SER_MW-1:0] fall;
   logic [SER_MW-1:0] evt_set;
   logic [SER_MW-1:0] evt_keep;
   logic [SER_MW-1:0] nxt_evt;
   logic [SER_MW-1:0] cond_up;
   logic [SER_MW-1:0] cond_dn;
   logic [SER_MW-1:0] evt_live;

   // Raw condition edges
   assign cond_up = cond & ~cond_ff;
   assign cond_dn = ~cond & cond_ff;
   assign rise = cond_up & ptr_ff;
   assign fall = cond_dn & ntr_ff;
   assign evt_set = rise | fall;
   // Clear after read, new edge wins
   assign evt_keep = rd_evt ? '0 : evt_ff;
   assign nxt_evt = evt_keep | evt_set;
   assign evt_live = evt_ff & en_ff;
   assign summary = |evt_live;

   assign en_q = en_ff;
   assign ptr_q = ptr_ff;
   assign ntr_q = ntr_ff;
   assign evt_q = evt_ff;

   // Previous condition for edge detect
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         cond_ff <= SER_MASK_RST;
      else
         cond_ff <= cond;
   end

   // Event latch
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         evt_ff <= SER_MASK_RST;
      else
         evt_ff <= nxt_evt;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         en_ff <= SER_MASK_RST;
      else if (wr_en)
         en_ff <= wdata;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         ptr_ff <= SER_MASK_RST;
      else if (wr_ptr)
         ptr_ff <= wdata;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         ntr_ff <= SER_MASK_RST;
      else if (wr_ntr)
         ntr_ff <= wdata;
   end
endmodule : ser_group

// Functional notes
// - Power bits 1 and 2 flag channel A and B input overload.
// - Power bits 3 and 4 flag channel A and B needing zeroing.
// - Power bits 5 to 8 flag invalid or failed-log measurement 1 to 4.
// - Device condition register is read-only, follows current state.
// - Device enable mask gates device events into status word bit 1.
// - Reading device event register returns it, then clears it.
// - Enable masks and transition filters hold 15 bits and read back.
// - Device negative filter latches one-to-zero condition changes.
// - Device positive filter latches zero-to-one condition changes.
// - Calibration condition bits 1 and 2 high while A or B calibrates.
// - Calibration enable mask gates events into operation bit 0.
// - Reading calibration event register returns it, then clears it.
// - Calibration group has its own positive and negative filters.
// - Operation condition bits 0, 5, 10: calibration, trigger, sensor summaries.
// - Operation condition bits 11 and 12: lower and upper limit summaries.
// - Operation enable mask gates events into status word bit 7.
module ser_status_top
   import ser_pkg::*;
#(
   parameter bit DUAL_CHAN = 1'b1
)
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire ser_cmd_t cmd,
   output ser_rsp_t rsp,
   input wire logic ovl_a,
   input wire logic ovl_b,
   input wire logic zero_req_a,
   input wire logic zero_req_b,
   input wire logic [PQ_MEAS_N-1:0] meas_bad,
   input wire logic [SER_MW-1:0] dev_cond,
   input wire logic cal_busy_a,
   input wire logic cal_busy_b,
   input wire logic trig_summary,
   input wire logic sense_summary,
   input wire logic llf_summary,
   input wire logic ulf_summary,
   output logic dev_summary,
   output logic opr_summary
);
   logic [SER_MW-1:0] pwr_cond;
   logic [SER_MW-1:0] cal_cond;
   logic [SER_MW-1:0] opr_cond;
   logic [SER_MW-1:0] wdata;
   logic [SER_MW-1:0] dev_en, dev_ptr, dev_ntr, dev_evt;
   logic [SER_MW-1:0] cal_en, cal_ptr, cal_ntr, cal_evt;
   logic [SER_MW-1:0] opr_en, opr_ptr, opr_ntr, opr_evt;
   logic cal_summary;
   logic wr_go;
   logic rd_go;
   logic [SER_MW-1:0] rd_mux;
   logic [SER_DW-1:0] rd_word;
   ser_rsp_t nxt_rsp;
   logic rsp_valid_ff;
   logic [SER_DW-1:0] rsp_data_ff;
   logic dual_ok;
   logic ovl_b_dual;
   logic zero_b_dual;
   logic cal_b_dual;

   // Per-register strobes
   logic dev_en_wr;
   logic dev_ptr_wr;
   logic dev_ntr_wr;

   logic cal_en_wr;
   logic cal_ptr_wr;
   logic cal_ntr_wr;

   logic opr_en_wr;
   logic opr_ptr_wr;
   logic opr_ntr_wr;

   logic dev_evt_rd;
   logic cal_evt_rd;
   logic opr_evt_rd;

   // Channel B bits exist only on dual builds
   assign dual_ok = DUAL_CHAN;
   assign ovl_b_dual = ovl_b & dual_ok;
   assign zero_b_dual = zero_req_b & dual_ok;
   assign cal_b_dual = cal_busy_b & dual_ok;

   // Power questionable bits, B overload and zeroing only on dual builds
   always_comb
   begin
      pwr_cond = '0;
      pwr_cond[PQ_OVL_A] = ovl_a;
      pwr_cond[PQ_OVL_B] = ovl_b_dual;
      pwr_cond[PQ_ZER_A] = zero_req_a;
      pwr_cond[PQ_ZER_B] = zero_b_dual;
      pwr_cond[PQ_MEAS_LO +: PQ_MEAS_N] = meas_bad;
   end

   always_comb
   begin
      cal_cond = '0;
      cal_cond[CAL_CH_A] = cal_busy_a;
      cal_cond[CAL_CH_B] = cal_b_dual;
   end

   // Operation summary bits 0, 5, 10, 11, 12
   always_comb
   begin
      opr_cond = '0;
      opr_cond[OPR_CAL] = cal_summary;
      opr_cond[OPR_TRIG] = trig_summary;
      opr_cond[OPR_SENSE] = sense_summary;
      opr_cond[OPR_LLF] = llf_summary;
      opr_cond[OPR_ULF] = ulf_summary;
   end

   assign wr_go = cmd.req & cmd.wr;
   assign rd_go = cmd.req & ~cmd.wr;
   assign wdata = cmd.wdata[SER_MW-1:0];

   // Device group writes
   assign dev_en_wr = wr_go && cmd.sel == SEL_DEV_EN;
   assign dev_ptr_wr = wr_go && cmd.sel == SEL_DEV_PTR;
   assign dev_ntr_wr = wr_go && cmd.sel == SEL_DEV_NTR;

   // Calibration group writes
   assign cal_en_wr = wr_go && cmd.sel == SEL_CAL_EN;
   assign cal_ptr_wr = wr_go && cmd.sel == SEL_CAL_PTR;
   assign cal_ntr_wr = wr_go && cmd.sel == SEL_CAL_NTR;

   // Operation group writes
   assign opr_en_wr = wr_go && cmd.sel == SEL_OPR_EN;
   assign opr_ptr_wr = wr_go && cmd.sel == SEL_OPR_PTR;
   assign opr_ntr_wr = wr_go && cmd.sel == SEL_OPR_NTR;

   assign dev_evt_rd = rd_go && cmd.sel == SEL_DEV_EVT;
   assign cal_evt_rd = rd_go && cmd.sel == SEL_CAL_EVT;
   // Operation event read strobe
   assign opr_evt_rd = rd_go && cmd.sel == SEL_OPR_EVT;

   // Device events gated into status bit 1
   ser_group u_dev (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .cond(dev_cond),
      .wdata(wdata),
      .wr_en(dev_en_wr),
      .wr_ptr(dev_ptr_wr),
      .wr_ntr(dev_ntr_wr),
      .rd_evt(dev_evt_rd),
      .en_q(dev_en),
      .ptr_q(dev_ptr),
      .ntr_q(dev_ntr),
      .evt_q(dev_evt),
      .summary(dev_summary)
   );

   // Calibration events gated into operation bit 0
   ser_group u_cal (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .cond(cal_cond),
      .wdata(wdata),
      .wr_en(cal_en_wr),
      .wr_ptr(cal_ptr_wr),
      .wr_ntr(cal_ntr_wr),
      .rd_evt(cal_evt_rd),
      .en_q(cal_en),
      .ptr_q(cal_ptr),
      .ntr_q(cal_ntr),
      .evt_q(cal_evt),
      .summary(cal_summary)
   );

   // Operation events gated into status bit 7
   ser_group u_opr (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .cond(opr_cond),
      .wdata(wdata),
      .wr_en(opr_en_wr),
      .wr_ptr(opr_ptr_wr),
      .wr_ntr(opr_ntr_wr),
      .rd_evt(opr_evt_rd),
      .en_q(opr_en),
      .ptr_q(opr_ptr),
      .ntr_q(opr_ntr),
      .evt_q(opr_evt),
      .summary(opr_summary)
   );

   always_comb
   begin
      unique case (cmd.sel)
         SEL_PWR_COND: rd_mux = pwr_cond;
         SEL_DEV_COND: rd_mux = dev_cond;
         SEL_DEV_EVT: rd_mux = dev_evt;
         SEL_DEV_EN: rd_mux = dev_en;
         SEL_DEV_PTR: rd_mux = dev_ptr;
         SEL_DEV_NTR: rd_mux = dev_ntr;
         SEL_CAL_COND: rd_mux = cal_cond;
         SEL_CAL_EVT: rd_mux = cal_evt;
         SEL_CAL_EN: rd_mux = cal_en;
         SEL_CAL_PTR: rd_mux = cal_ptr;
         SEL_CAL_NTR: rd_mux = cal_ntr;
         SEL_OPR_COND: rd_mux = opr_cond;
         SEL_OPR_EVT: rd_mux = opr_evt;
         SEL_OPR_EN: rd_mux = opr_en;
         SEL_OPR_PTR: rd_mux = opr_ptr;
         SEL_OPR_NTR: rd_mux = opr_ntr;
      endcase
   end

   assign rd_word = {1'b0, rd_mux};
   assign nxt_rsp.valid = cmd.req;
   assign nxt_rsp.data = rd_go ? rd_word : '0;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         rsp_valid_ff <= 1'b0;
      else
         rsp_valid_ff <= nxt_rsp.valid;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         rsp_data_ff <= '0;
      else
         rsp_data_ff <= nxt_rsp.data;
   end

   assign rsp.valid = rsp_valid_ff;
   assign rsp.data = rsp_data_ff;
endmodule : ser_status_top

// ==== tb/ser_status_monitor.sv ====
// Port checker for status event reporting
`timescale 1ns/1ps
module ser_status_monitor
   import ser_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire ser_cmd_t cmd,
   input wire ser_rsp_t rsp,
   input wire logic ovl_a,
   input wire logic ovl_b,
   input wire logic zero_req_a,
   input wire logic zero_req_b,
   input wire logic [PQ_MEAS_N-1:0] meas_bad,
   input wire logic [SER_MW-1:0] dev_cond,
   input wire logic cal_busy_a,
   input wire logic cal_busy_b,
   input wire logic trig_summary,
   input wire logic sense_summary,
   input wire logic llf_summary,
   input wire logic ulf_summary,
   input wire logic dev_summary,
   input wire logic opr_summary
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   wire logic rd = cmd.req && !cmd.wr;
   property p_vld; cmd.req |=> rsp.valid; endproperty
   a_vld: assert property (p_vld) else $error("missing response");
   property p_b15; rsp.data[15] == 1'h0; endproperty
   a_b15: assert property (p_b15) else $error("bit 15 set");
   property p_wr; cmd.req && cmd.wr |=> rsp.data == 16'h0000; endproperty
   a_wr: assert property (p_wr) else $error("write data nonzero");
   property p_pwr; rd && cmd.sel == SEL_PWR_COND |=> rsp.data == {7'h00, $past(meas_bad),
      $past(zero_req_b), $past(zero_req_a), $past(ovl_b), $past(ovl_a), 1'h0}; endproperty
   a_pwr: assert property (p_pwr) else $error("power word wrong");
   property p_devc; rd && cmd.sel == SEL_DEV_COND |=> rsp.data == {1'h0, $past(dev_cond)}; endproperty
   a_devc: assert property (p_devc) else $error("device cond wrong");
   property p_cal; rd && cmd.sel == SEL_CAL_COND |=> rsp.data == {13'h0000, $past(cal_busy_b),
      $past(cal_busy_a), 1'h0}; endproperty
   a_cal: assert property (p_cal) else $error("cal cond wrong");
   property p_opc; rd && cmd.sel == SEL_OPR_COND |=> rsp.data[12:10] == $past({ulf_summary,
      llf_summary, sense_summary}) && rsp.data[5] == $past(trig_summary); endproperty
   a_opc: assert property (p_opc) else $error("opr cond wrong");
   property p_clr;
      rd && cmd.sel == SEL_DEV_EVT && $stable(dev_cond) ##1 $stable(dev_cond) |=> !dev_summary;
   endproperty
   a_clr: assert property (p_clr) else $error("event not cleared");
   c_evt: cover property (rd && cmd.sel == SEL_DEV_EVT);
   c_ds: cover property ($rose(dev_summary));
   c_os: cover property ($rose(opr_summary));
endmodule : ser_status_monitor

// ==== tb/ser_status_top_tb.sv ====
// Self-checking bench for status event reporting
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module ser_status_top_tb import ser_pkg::*;;
   logic core_clk, rst_n, ovl_a, ovl_b, zero_req_a, zero_req_b, cal_busy_a, cal_busy_b;
   logic trig_summary, sense_summary, llf_summary, ulf_summary, dev_summary, opr_summary;
   logic [PQ_MEAS_N-1:0] meas_bad;
   logic [SER_MW-1:0] dev_cond;
   logic [SER_DW-1:0] rd;
   ser_cmd_t cmd;
   ser_rsp_t rsp;
   int fail_count, tests_run;
   ser_status_top dut_u (.*);
   initial
   begin
      core_clk = 1'h0;
      forever #10 core_clk = ~core_clk;
   end
   task automatic xfer(input logic w, input ser_sel_t s, input logic [15:0] d);
      @(posedge core_clk) #1;
      cmd = '{1'h1, w, s, d};
      @(posedge core_clk) #1;
      cmd.req = 1'h0;
      `CHK("valid", 1'h1, rsp.valid)
      rd = rsp.data;
   endtask : xfer
   task automatic t_regs;
      ser_sel_t m[9] = '{SEL_DEV_EN, SEL_DEV_PTR, SEL_DEV_NTR, SEL_CAL_EN, SEL_CAL_PTR,
         SEL_CAL_NTR, SEL_OPR_EN, SEL_OPR_PTR, SEL_OPR_NTR};
      foreach (m[i])
      begin
         xfer(1'h1, m[i], 16'hffff);
         `CHK("wr data", 16'h0000, rd)
         xfer(1'h0, m[i], 16'h0000);
         `CHK("readback", 16'h7fff, rd)
         xfer(1'h1, m[i], 16'h0000);
      end
      xfer(1'h1, SEL_DEV_COND, 16'h7fff);
      xfer(1'h0, SEL_DEV_COND, 16'h0000);
      `CHK("dev cond ro", 16'h0000, rd)
   endtask : t_regs
   task automatic t_pwr;
      {ovl_a, ovl_b, zero_req_a, zero_req_b, meas_bad} = 8'h8a;
      xfer(1'h0, SEL_PWR_COND, 16'h0000);
      `CHK("pwr a", 16'h0142, rd)
      {ovl_a, ovl_b, zero_req_a, zero_req_b, meas_bad} = 8'h75;
      xfer(1'h0, SEL_PWR_COND, 16'h0000);
      `CHK("pwr b", 16'h00bc, rd)
   endtask : t_pwr
   task automatic t_dev;
      dev_cond = 15'h0001;
      xfer(1'h1, SEL_DEV_PTR, 16'h0006);
      xfer(1'h1, SEL_DEV_NTR, 16'h0001);
      dev_cond = 15'h0006;
      xfer(1'h0, SEL_DEV_COND, 16'h0000);
      `CHK("dev cond", 16'h0006, rd)
      `CHK("dev sum off", 1'h0, dev_summary)
      xfer(1'h1, SEL_DEV_EN, 16'h0002);
      `CHK("dev sum on", 1'h1, dev_summary)
      xfer(1'h0, SEL_DEV_EVT, 16'h0000);
      `CHK("dev evt", 16'h0007, rd)
      xfer(1'h0, SEL_DEV_EVT, 16'h0000);
      `CHK("dev clr", 16'h0000, rd)
      `CHK("dev sum clr", 1'h0, dev_summary)
   endtask : t_dev
   task automatic t_cal;
      xfer(1'h1, SEL_OPR_PTR, 16'h0001);
      xfer(1'h1, SEL_OPR_EN, 16'h0001);
      xfer(1'h1, SEL_CAL_PTR, 16'h0002);
      xfer(1'h1, SEL_CAL_EN, 16'h0002);
      {cal_busy_a, cal_busy_b} = 2'h3;
      xfer(1'h0, SEL_CAL_COND, 16'h0000);
      `CHK("cal cond", 16'h0006, rd)
      xfer(1'h0, SEL_OPR_COND, 16'h0000);
      `CHK("opr cal bit", 16'h0001, rd)
      `CHK("opr sum", 1'h1, opr_summary)
      xfer(1'h0, SEL_CAL_EVT, 16'h0000);
      `CHK("cal evt", 16'h0002, rd)
      {trig_summary, sense_summary, llf_summary, ulf_summary} = 4'hf;
      xfer(1'h0, SEL_OPR_COND, 16'h0000);
      `CHK("opr cond", 16'h1c20, rd)
      xfer(1'h0, SEL_OPR_EVT, 16'h0000);
      `CHK("opr evt", 16'h0001, rd)
      `CHK("opr sum clr", 1'h0, opr_summary)
      xfer(1'h1, SEL_CAL_NTR, 16'h0004);
      cal_busy_b = 1'h0;
      xfer(1'h0, SEL_CAL_EVT, 16'h0000);
      `CHK("cal ntr", 16'h0004, rd)
      xfer(1'h0, SEL_CAL_EVT, 16'h0000);
      `CHK("cal clr", 16'h0000, rd)
   endtask : t_cal
   task automatic give_verdict;
      $display("checks %0d failures %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   initial
   begin
      {ovl_a, ovl_b, zero_req_a, zero_req_b, meas_bad, dev_cond, cal_busy_a, cal_busy_b,
         trig_summary, sense_summary, llf_summary, ulf_summary} = '0;
      cmd = '0;
      rst_n = 1'h0;
      repeat (3) @(posedge core_clk);
      #1 rst_n = 1'h1;
      t_regs;
      t_pwr;
      t_dev;
      t_cal;
      give_verdict;
   end
   initial
   begin
      #50us;
      fail_count++;
      give_verdict;
   end
endmodule : ser_status_top_tb
bind ser_status_top ser_status_monitor mon_u (.*);
